// ---- hw/csad_decoder.sv ----
// chip select area decoder with per-area width, wait and interface selection
`timescale 1ns/1ps
module csad_decoder (
	input wire logic MCLK_I,
	input wire logic RSTN_I,
	input wire logic ACC_REQ_I,
	input wire logic [31:0] ACC_ADDR_I,
	input wire logic ACC_WRITE_I,
	input wire logic [5*16-1:0] AREA_BASE_MATCH_I,
	input wire logic [5*16-1:0] AREA_COMPARE_MASK_I,
	input wire logic [6*6-1:0] AREA_INTERFACE_CONFIG_I,
	input wire logic [1:0] DRAM_TYPE4_I,
	input wire logic [1:0] DRAM_TYPE5_I,
	input wire logic DRAM_TWO_WE_I,
	input wire logic DRAM_PAGE_MODE_I,
	input wire logic REFRESH_REQ_I,
	input wire logic SELF_REFRESH_I,
	input wire logic LITTLE_ENDIAN_I,
	input wire logic [31:0] WDATA_I,
	output logic ACC_READY_O,
	output logic [24:0] EXT_ADDR_O,
	output logic [15:0] EXT_WDATA_O,
	output logic [5:0] AREA_SELECT_N_O,
	output logic BUS_WIDE16_O,
	output logic [2:0] AREA_NUM_O,
	output logic [1:0] ROW_STROBE_N_O,
	output logic [1:0] COL_STROBE_N_O,
	output logic [1:0] WRITE_EN_N_O,
	output logic DATA_HI_PORT_EN_O
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		csad_pkg::csad_st_e st;
		logic [2:0] cnt;
		logic [2:0] area;
		logic [24:0] addr;
		logic [15:0] wdata;
		logic [5:0] sel_n;
		logic wide;
		logic [1:0] ras_n;
		logic [1:0] cas_n;
		logic [1:0] we_n;
		logic ready;
		logic port_en;
	} csad_state_s;

	csad_state_s state_reg;
	csad_state_s state_next;

	// lowest numbered hit wins, so overlapping areas resolve downwards
	function automatic logic [2:0] csad_area(input logic [csad_pkg::N_PROG-1:0] hits);
		logic [2:0] num;
		num = 3'h0;
		for (int i = csad_pkg::N_PROG - 1; i >= 0; i--) begin
			if (hits[i]) begin
				num = 3'(i + 1);
			end
		end
		return num;
	endfunction : csad_area

	// masked compare of one select value against address bits 31:16
	function automatic logic csad_match(input logic [31:0] a, input logic [15:0] base,
			input logic [15:0] mask);
		logic [15:0] diff;
		diff = (a[31:16] ^ base) & ~mask;
		return diff == 16'h0000;
	endfunction : csad_match

	function automatic csad_pkg::csad_cfg_s csad_cfg(input logic [35:0] cfgs,
			input logic [2:0] area);
		csad_pkg::csad_cfg_s c;
		c = csad_pkg::csad_cfg_s'(cfgs[area*6 +: 6]);
		if (c.iface != csad_pkg::CSAD_IF_DRAM || area < 3'(csad_pkg::DRAM_FIRST)) begin
			c.iface = csad_pkg::CSAD_IF_USUAL;
		end
		return c;
	endfunction : csad_cfg

	////////////////////////////////////////////////////////////////////////
	// programmable area hits, bit g for area g+1
	logic [csad_pkg::N_PROG-1:0] area_hit;
	// settings of every area, already legalised
	csad_pkg::csad_cfg_s area_cfg [csad_pkg::N_AREAS];
	logic [2:0] hit_area;
	csad_pkg::csad_cfg_s hit_cfg;
	logic bank;
	logic [1:0] dtype;
	logic dram_hit;
	logic cas_own;
	logic [5:0] acc_sel_n;
	logic [1:0] acc_ras_n;
	logic [1:0] acc_cas_n;
	logic [1:0] acc_we_n;
	logic [15:0] acc_wdata;

	////////////////////////////////////////////////////////////////////////
	// one masked compare per programmable area
	for (genvar g = 0; g < csad_pkg::N_PROG; g++) begin : g_match
		assign area_hit[g] = csad_match(ACC_ADDR_I,
			AREA_BASE_MATCH_I[g*csad_pkg::MATCH_W +: csad_pkg::MATCH_W],
			AREA_COMPARE_MASK_I[g*csad_pkg::MATCH_W +: csad_pkg::MATCH_W]);
	end : g_match

	// each area's settings decoded on their own
	for (genvar g = 0; g < csad_pkg::N_AREAS; g++) begin : g_cfg
		assign area_cfg[g] = csad_cfg(AREA_INTERFACE_CONFIG_I, 3'(g));
	end : g_cfg

	always_comb begin
		hit_area = csad_area(area_hit);
		hit_cfg = area_cfg[hit_area];
		bank = (hit_area == 3'h5);
		dtype = bank ? DRAM_TYPE5_I : DRAM_TYPE4_I;
		dram_hit = (hit_cfg.iface == csad_pkg::CSAD_IF_DRAM);
		// single CAS and 1CAS/2WE parts strobe only the addressed bank's CAS
		cas_own = DRAM_TWO_WE_I || (dtype == csad_pkg::CSAD_DR_SINGLE_CAS);
		// one select per area; DRAM areas use row strobes instead
		acc_sel_n = csad_pkg::SEL_IDLE;
		if (!dram_hit) begin
			acc_sel_n[hit_area] = 1'b0;
		end
		acc_wdata = LITTLE_ENDIAN_I ? {WDATA_I[7:0], WDATA_I[15:8]} : WDATA_I[15:0];
	end

	// row, column and write strobes, one set per DRAM bank
	for (genvar b = 0; b < 2; b++) begin : g_bank
		logic bank_hit;

		assign bank_hit = dram_hit && (bank == 1'(b));
		assign acc_ras_n[b] = ~bank_hit;
		assign acc_cas_n[b] = !dram_hit || (cas_own && !bank_hit);
		assign acc_we_n[b] = !dram_hit || !ACC_WRITE_I;
	end : g_bank

	always_comb begin
		state_next = state_reg;
		state_next.ready = 1'b0;
		unique case (state_reg.st)
			csad_pkg::CSAD_IDLE: begin
				state_next.sel_n = csad_pkg::SEL_IDLE;
				state_next.ras_n = 2'h3;
				state_next.cas_n = 2'h3;
				state_next.we_n = 2'h3;
				// refresh: CAS before RAS, held while self-refresh
				if (REFRESH_REQ_I || SELF_REFRESH_I) begin
					state_next.cas_n = 2'h0;
					state_next.st = csad_pkg::CSAD_WAIT;
					state_next.cnt = 3'h1;
					state_next.area = 3'h0;
				end else if (ACC_REQ_I) begin
					state_next.area = hit_area;
					state_next.addr = ACC_ADDR_I[24:0];
					state_next.wdata = acc_wdata;
					state_next.wide = hit_cfg.wide16;
					// upper data lanes free when 8-bit
					state_next.port_en = ~hit_cfg.wide16;
					state_next.cnt = hit_cfg.waits;
					state_next.st = csad_pkg::CSAD_WAIT;
					state_next.sel_n = acc_sel_n;
					state_next.ras_n = acc_ras_n;
					state_next.cas_n = acc_cas_n;
					state_next.we_n = acc_we_n;
				end
			end
			csad_pkg::CSAD_WAIT: begin
				if (state_reg.cnt == 3'h0) begin
					state_next.st = csad_pkg::CSAD_DONE;
				end else begin
					state_next.cnt = state_reg.cnt - 3'h1;
				end
				if (state_reg.area == 3'h0 && state_reg.cas_n == 2'h0 &&
						state_reg.sel_n == csad_pkg::SEL_IDLE) begin
					state_next.ras_n = 2'h0;
				end
			end
			csad_pkg::CSAD_DONE: begin
				state_next.ready = (state_reg.ras_n == 2'h3) ||
					(state_reg.sel_n != csad_pkg::SEL_IDLE) || !DRAM_PAGE_MODE_I;
				if (SELF_REFRESH_I && state_reg.ras_n == 2'h0
						&& state_reg.sel_n == csad_pkg::SEL_IDLE) begin
					state_next.st = csad_pkg::CSAD_DONE;
				end else begin
					state_next.sel_n = csad_pkg::SEL_IDLE;
					state_next.cas_n = 2'h3;
					state_next.we_n = 2'h3;
					// page mode keeps row open to shorten next access
					if (!DRAM_PAGE_MODE_I || state_reg.area == 3'h0) begin
						state_next.ras_n = 2'h3;
					end
					state_next.ready = 1'b1;
					state_next.st = csad_pkg::CSAD_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state_reg.st <= csad_pkg::CSAD_IDLE;
			state_reg.cnt <= 3'h0;
			state_reg.area <= 3'h0;
			state_reg.addr <= 25'h0000000;
			state_reg.wdata <= 16'h0000;
			state_reg.sel_n <= csad_pkg::SEL_IDLE;
			state_reg.wide <= 1'b0;
			state_reg.ras_n <= 2'h3;
			state_reg.cas_n <= 2'h3;
			state_reg.we_n <= 2'h3;
			state_reg.ready <= 1'b0;
			state_reg.port_en <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// 64 KB granularity via bits 31:16
	assign EXT_ADDR_O = state_reg.addr;
	assign EXT_WDATA_O = state_reg.wdata;
	assign AREA_SELECT_N_O = state_reg.sel_n;
	assign BUS_WIDE16_O = state_reg.wide;
	assign AREA_NUM_O = state_reg.area;
	assign ROW_STROBE_N_O = state_reg.ras_n;
	assign COL_STROBE_N_O = state_reg.cas_n;
	assign WRITE_EN_N_O = state_reg.we_n;
	assign DATA_HI_PORT_EN_O = state_reg.port_en;
	assign ACC_READY_O = state_reg.ready;
endmodule : csad_decoder

// ---- shared/csad_pkg.sv ----
// constants and carrier types for the chip select area decoder
package csad_pkg;
	localparam int N_AREAS = 6;
	localparam int N_PROG = 5;
	localparam int ADDR_W = 32;
	localparam int EXT_ADDR_W = 25;
	localparam int MATCH_W = 16;
	localparam int MATCH_LSB = 16;
	localparam int WAIT_W = 3;
	localparam int DRAM_FIRST = 4;
	localparam logic [2:0] WAIT_RESET = 3'h7;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [N_AREAS-1:0] SEL_IDLE = 6'h3f;

	typedef enum logic [1:0] {
		CSAD_IF_USUAL,
		CSAD_IF_DRAM,
		CSAD_IF_RSVD2,
		CSAD_IF_RSVD3
	} csad_if_e;

	typedef enum logic [1:0] {
		CSAD_DR_DOUBLE_CAS,
		CSAD_DR_SINGLE_CAS,
		CSAD_DR_HYPER,
		CSAD_DR_RSVD
	} csad_dram_e;

	typedef struct packed {
		logic wide16;
		logic [WAIT_W-1:0] waits;
		csad_if_e iface;
	} csad_cfg_s;

	typedef enum {
		CSAD_IDLE,
		CSAD_WAIT,
		CSAD_DONE
	} csad_st_e;
endpackage : csad_pkg

// ---- verif/csad_decoder_sva.sv ----
// port assertions for the chip select area decoder
`timescale 1ns/1ps
module csad_decoder_chk (
	input wire logic MCLK_I,
	input wire logic RSTN_I,
	input wire logic [31:0] ACC_ADDR_I,
	input wire logic [6*6-1:0] AREA_INTERFACE_CONFIG_I,
	input wire logic ACC_READY_O,
	input wire logic [24:0] EXT_ADDR_O,
	input wire logic [5:0] AREA_SELECT_N_O,
	input wire logic BUS_WIDE16_O,
	input wire logic [2:0] AREA_NUM_O,
	input wire logic [1:0] ROW_STROBE_N_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RSTN_I);
	wire logic busy = AREA_SELECT_N_O != 6'h3f;
	//////////////////////////////////////////////////////////////////
	reset_high_a: assert property ($rose(RSTN_I) |-> AREA_SELECT_N_O[5:1] == 5'h1f)
		else $error("selects not idle after reset");
	ready_pulse_a: assert property (ACC_READY_O |=> !ACC_READY_O)
		else $error("ready longer than one cycle");
	ready_release_a: assert property (ACC_READY_O |-> !busy)
		else $error("select low at ready");
	one_area_a: assert property ($onehot0(~AREA_SELECT_N_O))
		else $error("several selects low");
	area_match_a: assert property (busy |-> ~AREA_SELECT_N_O == 6'h01 << AREA_NUM_O)
		else $error("select does not match area");
	addr_out_a: assert property (busy |-> EXT_ADDR_O == ACC_ADDR_I[24:0])
		else $error("external address wrong");
	width_cfg_a: assert property (busy |->
		BUS_WIDE16_O == AREA_INTERFACE_CONFIG_I[6*AREA_NUM_O+5])
		else $error("bus width wrong");
	dram_area_a: assert property (busy && AREA_NUM_O < 3'h4 |-> ROW_STROBE_N_O == 2'h3)
		else $error("row strobe in usual area");
	select_hold_a: assert property (busy |=> busy || ACC_READY_O)
		else $error("select dropped before ready");
endmodule : csad_decoder_chk
bind csad_decoder csad_decoder_chk chk (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .ACC_ADDR_I(ACC_ADDR_I),
	.AREA_INTERFACE_CONFIG_I(AREA_INTERFACE_CONFIG_I), .ACC_READY_O(ACC_READY_O),
	.EXT_ADDR_O(EXT_ADDR_O), .AREA_SELECT_N_O(AREA_SELECT_N_O), .BUS_WIDE16_O(BUS_WIDE16_O),
	.AREA_NUM_O(AREA_NUM_O), .ROW_STROBE_N_O(ROW_STROBE_N_O));

// ---- verif/csad_ext_model.sv ----
// external device stand-in that records the last area it saw selected
`timescale 1ns/1ps
module csad_ext_model (
	input wire logic clk_i,
	input wire logic [5:0] sel_n_i,
	output logic [2:0] last_o
);
	always_ff @(posedge clk_i) begin
		for (int k = 0; k < 6; k++) begin
			if (!sel_n_i[k]) last_o <= 3'(k);
		end
	end
endmodule : csad_ext_model

// ---- verif/tb_top.sv ----
// self-checking bench for the chip select area decoder
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, rst_n = 0, req = 0, wr = 0, le = 0, rfr = 0;
	logic [31:0] addr = 32'h0, wdata = 32'h0;
	logic [79:0] base = {16'h0005, 16'h0004, 16'h0003, 16'h0002, 16'h0001};
	logic [79:0] mask = 80'h0;
	logic [35:0] cfg = {6'h34, 6'h29, 6'h04, 6'h2c, 6'h1c, 6'h20};
	logic [1:0] dtype = 2'h0;
	wire logic rdy, wide, dhi;
	wire logic [24:0] xaddr;
	wire logic [15:0] xdata;
	wire logic [5:0] sel_n;
	wire logic [2:0] num, last;
	wire logic [1:0] ras_n, cas_n, we_n;
	int fail_count = 0, comparisons = 0;
	logic [31:0] row_addr [8] = '{32'h00001234, 32'h00010000, 32'h0002ffff, 32'h00038000,
		32'h00040010, 32'h0005fffe, 32'h00060000, 32'hffff0000};
	logic [2:0] row_area [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h0};
	always #20 clk = ~clk;
	csad_decoder dut (.MCLK_I(clk), .RSTN_I(rst_n), .ACC_REQ_I(req), .ACC_ADDR_I(addr),
		.ACC_WRITE_I(wr), .AREA_BASE_MATCH_I(base), .AREA_COMPARE_MASK_I(mask),
		.AREA_INTERFACE_CONFIG_I(cfg), .DRAM_TYPE4_I(dtype), .DRAM_TYPE5_I(~dtype),
		.DRAM_TWO_WE_I(1'b0), .DRAM_PAGE_MODE_I(1'b0), .REFRESH_REQ_I(rfr),
		.SELF_REFRESH_I(1'b0), .LITTLE_ENDIAN_I(le), .WDATA_I(wdata), .ACC_READY_O(rdy),
		.EXT_ADDR_O(xaddr), .EXT_WDATA_O(xdata), .AREA_SELECT_N_O(sel_n), .BUS_WIDE16_O(wide),
		.AREA_NUM_O(num), .ROW_STROBE_N_O(ras_n), .COL_STROBE_N_O(cas_n), .WRITE_EN_N_O(we_n),
		.DATA_HI_PORT_EN_O(dhi));
	csad_ext_model ext (.clk_i(clk), .sel_n_i(sel_n), .last_o(last));
	//////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task conclude;
		if (fail_count == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : conclude
	// request held until the ready cycle, dropped so the next edge is free
	task access(input logic [31:0] a, input logic [2:0] ar);
		logic [2:0] w;
		logic got;
		w = cfg[6*ar+2 +: 3];
		got = 0;
		@(posedge clk);
		req <= 1;
		addr <= a;
		wdata <= ~a;
		wr <= a[16];
		le <= a[12];
		dtype <= a[17:16];
		for (int n = 0; n < 14 && !got; n++) begin
			@(posedge clk);
			// request released at the edge that launches ready
			if (n == w + 2) req <= 0;
			#1;
			if (n == 1) begin
				check({sel_n, ras_n, wide}, {ar == 4 ? 6'h3f : ~(6'h01 << ar),
					ar == 4 ? 2'h2 : 2'h3, cfg[6*ar+5]});
				check(xaddr, a[24:0]);
				check(xdata, a[12] ? {~a[7:0], ~a[15:8]} : a[15:0] ^ 16'hffff);
				check(dhi, !cfg[6*ar+5]);
				check(num, ar);
				check({cas_n, we_n}, ar == 4 ? {2'h0, {2{~a[16]}}} : 4'hf);
			end
			if (rdy === 1'b1) begin
				got = 1;
				check(n, w + 2);
				check(sel_n, 6'h3f);
				if (ar != 4) check(last, ar);
			end
		end
		if (!got) begin
			fail_count++;
			conclude();
		end
	endtask : access
	//////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		check(sel_n[5:1], 5'h1f);
		rst_n <= 1;
		for (int i = 0; i < 8; i++) access(row_addr[i], row_area[i]);
		// area 2 widened to 256 KB, overlaps resolve to the lower area
		@(posedge clk);
		mask[31:16] <= 16'h0003;
		access(32'h00018000, 3'h1);
		access(32'h00004000, 3'h2);
		access(32'h00030000, 3'h2);
		// refresh: column strobes fall a cycle before row strobes
		@(posedge clk);
		rfr <= 1;
		@(posedge clk);
		rfr <= 0;
		#1;
		check({ras_n, cas_n}, 4'hc);
		@(posedge clk);
		#1;
		check({ras_n, cas_n, sel_n}, 10'h03f);
		repeat (4) @(posedge clk);
		// reset in the middle of an access
		req <= 1;
		addr <= 32'h00010000;
		repeat (2) @(posedge clk);
		rst_n <= 0;
		req <= 0;
		@(posedge clk);
		check({rdy, sel_n, ras_n}, 9'h0ff);
		rst_n <= 1;
		access(32'h00050000, 3'h5);
		conclude();
	end
endmodule : tb_top
